// [hdl/cpufr_flag_register.sv]
`timescale 1ns/1ns
// Operation
// [RULE1] The bank select flag picks general register bank 0 when 0 and bank 1 when 1.
// [RULE2] Each arithmetic operation sets the overflow flag on overflow and clears it otherwise.
// [RULE3] Maskable interrupts are accepted only while the interrupt enable flag is 1.
// [RULE4] Accepting any interrupt clears the interrupt enable flag.
// [RULE5] Stack select 0 picks the interrupt stack pointer, 1 the user stack pointer.
// [RULE6] Stack select clears on a hardware interrupt or a software trap numbered 0 to 127.
// [RULE7] Each float operation sets the underflow flag on underflow or subnormal operand.
// [RULE8] Each float operation sets the overflow flag on overflow or subnormal operand.
// [RULE9] A 3-bit priority level field holds levels 0 to 7.
// [RULE10] A request is enabled only when its level is strictly above the priority level.
// [RULE11] At priority level 7 no interrupt request is accepted.
// [RULE12] The radix point bit selects which product slice the fixed-point multiply returns.
// [RULE13] Float results round by the 2-bit rounding mode field.
// [RULE14] Software writes 0 to the reserved bit and ignores its read value.
// [RULE15] Acceptance saves the old flag word before clearing enable and stack select.
module cpufr_flag_register #(
  parameter int TRAP_WIDTH = 8 // Software trap number width
) (
  input wire logic clk, // Core clock
  input wire logic nrst, // Async reset, active low
  input wire logic [3:0] regAddr, // Register address
  input wire logic [15:0] regWdata, // Write data
  input wire logic regWrite, // Write strobe
  input wire logic regRead, // Read strobe
  output logic [15:0] regRdata, // Read data, cycle after strobe
  input wire logic arithDone, // Arithmetic op completes
  input wire logic arithOverflow, // Its result overflowed
  input wire logic floatDone, // Float op completes
  input wire logic floatUnderflow, // Float underflow
  input wire logic floatOverflow, // Float overflow
  input wire logic floatSubnormal, // Operand was subnormal
  input wire logic irqRequest, // Hardware interrupt request
  input wire logic [2:0] irqLevel, // Its request level
  input wire logic irqMaskable, // Request is maskable
  input wire logic trapExec, // Software trap executes
  input wire logic [TRAP_WIDTH-1:0] trapNumber, // Trap number
  output logic irqAccept, // Interrupt taken this cycle
  output logic registerBank, // Active register bank
  output logic userStackSelect, // 1: user stack pointer
  output logic radixPointSelect, // Fixed-point product slice
  output logic [1:0] roundingModeField, // Float rounding mode
  output logic [2:0] processorPriorityLevel, // Current priority
  output logic [15:0] flagWord, // Whole flag register
  output logic irqOut // Event interrupt, level
);
  import cpufr_pkg::*;

  logic [15:0] flags;
  logic [15:0] savedFlags;
  logic [EV_WIDTH-1:0] evStatus;
  logic [EV_WIDTH-1:0] evEnable;
  logic [EV_WIDTH-1:0] evSet;
  logic trapClears;
  logic flagWrite;

  // Level gate shared by the accept logic and its checks
  function automatic logic level_passes(input logic [2:0] req, input logic [2:0] ppl);
    level_passes = (ppl != PPL_BLOCK_ALL) && (req > ppl);
  endfunction : level_passes

  // Acceptance: level first, then the enable flag for maskable sources
  assign irqAccept = irqRequest && level_passes(irqLevel, flags[POS_PPL+:3]) // [RULE10] [RULE11]
    && (!irqMaskable || flags[POS_IEN]); // [RULE3]
  assign trapClears = trapExec && ({{(32-TRAP_WIDTH){1'b0}}, trapNumber} <= 32'(TRAP_MAX_CLEAR));
  assign flagWrite = regWrite && (regAddr == ADDR_FLAG);

  // Flag register; hardware events win over a same-cycle software write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags <= FLG_RESET;
    end else begin
      logic [15:0] nextFlags;
      nextFlags = flags;
      if (flagWrite) begin
        nextFlags = regWdata & FLG_WMASK; // [RULE14]
      end
      if (arithDone) begin
        nextFlags[POS_OVF] = arithOverflow; // [RULE2]
      end
      if (floatDone) begin
        nextFlags[POS_FUF] = floatUnderflow || floatSubnormal; // [RULE7]
        nextFlags[POS_FOF] = floatOverflow || floatSubnormal; // [RULE8]
      end
      if (irqAccept) begin
        nextFlags[POS_IEN] = 1'b0; // [RULE4]
        nextFlags[POS_SSEL] = 1'b0; // [RULE6]
      end
      if (trapClears) begin
        nextFlags[POS_SSEL] = 1'b0; // [RULE6]
      end
      flags <= nextFlags;
    end
  end

  // Snapshot of the interrupted state, taken before the clears land
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      savedFlags <= FLG_RESET;
    end else if (irqAccept || trapClears) begin
      savedFlags <= flags; // [RULE15]
    end
  end

  // Field outputs steer bank, stack, multiplier and rounding logic
  assign registerBank = flags[POS_BANK]; // [RULE1]
  assign userStackSelect = flags[POS_SSEL]; // [RULE5]
  assign radixPointSelect = flags[POS_RADIX]; // [RULE12]
  assign roundingModeField = flags[POS_RND+:2]; // [RULE13]
  assign processorPriorityLevel = flags[POS_PPL+:3]; // [RULE9]
  assign flagWord = flags;

  // Sticky event status; a set in the clear cycle wins
  assign evSet = {floatDone && (floatUnderflow || floatOverflow || floatSubnormal),
                  arithDone && arithOverflow, irqAccept};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      evStatus <= '0;
    end else if (regWrite && regAddr == ADDR_ICLR) begin
      evStatus <= (evStatus & ~regWdata[EV_WIDTH-1:0]) | evSet;
    end else begin
      evStatus <= evStatus | evSet;
    end
  end

  // Interrupt enable mask
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      evEnable <= '0;
    end else if (regWrite && regAddr == ADDR_IEN) begin
      evEnable <= regWdata[EV_WIDTH-1:0];
    end
  end

  assign irqOut = |(evStatus & evEnable);

  // Read data one cycle after the strobe, zero otherwise and for unmapped offsets
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= '0;
    end else if (regRead) begin
      unique case (regAddr)
        ADDR_FLAG: regRdata <= flags;
        ADDR_SAVED: regRdata <= savedFlags;
        ADDR_ISTAT: regRdata <= {13'h0000, evStatus};
        ADDR_IEN: regRdata <= {13'h0000, evEnable};
        default: regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // Checks
  sequence s_accept;
    irqAccept;
  endsequence
  sequence s_cleared;
    !flags[POS_IEN] && !flags[POS_SSEL];
  endsequence

  a_accept_clears: assert property (@(posedge clk) disable iff (!nrst) // RULE4
    s_accept |=> s_cleared) else $error("accept did not clear enable and stack select");
  a_mask_blocks: assert property (@(posedge clk) disable iff (!nrst) // RULE3
    (irqMaskable && !flags[POS_IEN]) |-> !irqAccept) else $error("masked interrupt taken");
  a_level_gate: assert property (@(posedge clk) disable iff (!nrst) // RULE10
    irqAccept |-> irqLevel > processorPriorityLevel) else $error("level not above priority");
  a_level_seven: assert property (@(posedge clk) disable iff (!nrst) // RULE11
    processorPriorityLevel == 3'h7 |-> !irqAccept) else $error("accept at level 7");
  a_ovf_track: assert property (@(posedge clk) disable iff (!nrst) // RULE2
    arithDone |=> flags[POS_OVF] == $past(arithOverflow)) else $error("overflow flag wrong");
  a_fuf_track: assert property (@(posedge clk) disable iff (!nrst) // RULE7
    floatDone |=> flags[POS_FUF] == $past(floatUnderflow || floatSubnormal))
    else $error("float underflow flag wrong");
  a_fof_track: assert property (@(posedge clk) disable iff (!nrst) // RULE8
    floatDone |=> flags[POS_FOF] == $past(floatOverflow || floatSubnormal))
    else $error("float overflow flag wrong");
  a_trap_ssel: assert property (@(posedge clk) disable iff (!nrst) // RULE6
    (trapExec && trapNumber <= 127) |=> !userStackSelect) else $error("trap kept user stack");
  a_save_state: assert property (@(posedge clk) disable iff (!nrst) // RULE15
    irqAccept |=> savedFlags == $past(flags)) else $error("state not saved");
  a_bank_out: assert property (@(posedge clk) disable iff (!nrst) // RULE1
    flagWrite && !arithDone |=> registerBank == $past(regWdata[POS_BANK]))
    else $error("bank select not written");

  // Software flag write, the common trigger of the field checks below
  sequence s_flag_write;
    flagWrite;
  endsequence
  // Write with no hardware clear landing in the same cycle
  sequence s_plain_write;
    flagWrite && !irqAccept && !trapClears;
  endsequence
  // A request that passes every gate, so it must be taken
  sequence s_gates_open;
    irqRequest && (irqLevel > processorPriorityLevel) && (processorPriorityLevel != 3'h7)
      && (!irqMaskable || flags[POS_IEN]);
  endsequence

  // Field writes land whole in the next cycle
  a_ppl_write: assert property (@(posedge clk) disable iff (!nrst) // [RULE9]
    s_flag_write |=> processorPriorityLevel == $past(regWdata[POS_PPL+:3]))
    else $error("priority level not written");
  // Radix select follows the written bit
  a_radix_write: assert property (@(posedge clk) disable iff (!nrst) // [RULE12]
    s_flag_write |=> radixPointSelect == $past(regWdata[POS_RADIX]))
    else $error("radix select not written");
  // Rounding mode follows the written field
  a_rnd_write: assert property (@(posedge clk) disable iff (!nrst) // [RULE13]
    s_flag_write |=> roundingModeField == $past(regWdata[POS_RND+:2]))
    else $error("rounding mode not written");
  // Enable flag takes the written value unless an accept clears it
  a_ien_write: assert property (@(posedge clk) disable iff (!nrst) // [RULE3]
    s_plain_write |=> flags[POS_IEN] == $past(regWdata[POS_IEN]))
    else $error("enable flag not written");
  // Stack select takes the written value unless hardware clears it
  a_ssel_write: assert property (@(posedge clk) disable iff (!nrst) // [RULE5]
    s_plain_write |=> userStackSelect == $past(regWdata[POS_SSEL]))
    else $error("stack select not written");
  // Reserved bit never reads back as one, whatever software wrote
  a_rsv_zero: assert property (@(posedge clk) disable iff (!nrst) // [RULE14]
    !flags[POS_RSV]) else $error("reserved bit set");

  // Fields only software owns stay put without a write
  a_bank_hold: assert property (@(posedge clk) disable iff (!nrst) // [RULE1]
    !flagWrite |=> $stable(registerBank)) else $error("bank select moved");
  // Priority level cannot drift on its own
  a_ppl_hold: assert property (@(posedge clk) disable iff (!nrst) // [RULE9]
    !flagWrite |=> $stable(processorPriorityLevel)) else $error("priority level moved");
  // Radix select cannot drift on its own
  a_radix_hold: assert property (@(posedge clk) disable iff (!nrst) // [RULE12]
    !flagWrite |=> $stable(radixPointSelect)) else $error("radix select moved");
  // Rounding mode cannot drift on its own
  a_rnd_hold: assert property (@(posedge clk) disable iff (!nrst) // [RULE13]
    !flagWrite |=> $stable(roundingModeField)) else $error("rounding mode moved");
  // Overflow flag only moves on an arithmetic result or a write
  a_ovf_hold: assert property (@(posedge clk) disable iff (!nrst) // [RULE2]
    !arithDone && !flagWrite |=> $stable(flags[POS_OVF])) else $error("overflow flag moved");
  // Float underflow only moves on a float result or a write
  a_fuf_hold: assert property (@(posedge clk) disable iff (!nrst) // [RULE7]
    !floatDone && !flagWrite |=> $stable(flags[POS_FUF])) else $error("underflow flag moved");
  // Float overflow only moves on a float result or a write
  a_fof_hold: assert property (@(posedge clk) disable iff (!nrst) // [RULE8]
    !floatDone && !flagWrite |=> $stable(flags[POS_FOF])) else $error("float ovf flag moved");

  // Hardware acceptance always leaves the interrupt stack selected
  a_ssel_hw: assert property (@(posedge clk) disable iff (!nrst) // [RULE6]
    irqAccept |=> !userStackSelect) else $error("accept kept user stack");
  // High trap numbers leave the stack select alone
  a_trap_high: assert property (@(posedge clk) disable iff (!nrst) // [RULE6]
    trapExec && trapNumber > 127 && !irqAccept && !flagWrite |=> $stable(userStackSelect))
    else $error("high trap changed stack select");
  // Every open request is taken in the same cycle
  a_gates_take: assert property (@(posedge clk) disable iff (!nrst) // [RULE10]
    s_gates_open |-> irqAccept) else $error("open request not taken");
  // Nothing is taken without a request
  a_no_request: assert property (@(posedge clk) disable iff (!nrst) // [RULE10]
    !irqRequest |-> !irqAccept) else $error("accept without request");
  // Non-maskable sources bypass the enable flag but not the level gate
  a_nomask_pass: assert property (@(posedge clk) disable iff (!nrst) // [RULE3]
    irqRequest && !irqMaskable && level_passes(irqLevel, processorPriorityLevel) |-> irqAccept)
    else $error("non-maskable request refused");

  // Trap snapshot matches the word before the clear
  a_trap_save: assert property (@(posedge clk) disable iff (!nrst) // [RULE15]
    trapClears |=> savedFlags == $past(flags)) else $error("trap state not saved");
  // Snapshot is untouched between acceptances and traps numbered 0 to 127
  a_saved_hold: assert property (@(posedge clk) disable iff (!nrst) // [RULE15]
    !irqAccept && !trapClears |=> $stable(savedFlags)) else $error("saved flags moved");

  // Status bits record the events
  a_acc_status: assert property (@(posedge clk) disable iff (!nrst) // [RULE4]
    irqAccept |=> evStatus[EV_ACCEPT]) else $error("accept not recorded");
  // Overflow result raises its status bit
  a_ovf_status: assert property (@(posedge clk) disable iff (!nrst) // [RULE2]
    arithDone && arithOverflow |=> evStatus[EV_OVF]) else $error("overflow not recorded");
  // Subnormal operand raises the float status bit
  a_flt_status: assert property (@(posedge clk) disable iff (!nrst) // [RULE7]
    floatDone && floatSubnormal |=> evStatus[EV_FLT]) else $error("float event not recorded");
  // Status stays sticky until cleared
  a_ev_sticky: assert property (@(posedge clk) disable iff (!nrst) // [RULE4]
    evStatus[EV_ACCEPT] && !(regWrite && regAddr == ADDR_ICLR) |=> evStatus[EV_ACCEPT])
    else $error("status bit lost");

  // Read port returns the word as it stood at the strobe
  a_read_flag: assert property (@(posedge clk) disable iff (!nrst) // [RULE9]
    regRead && regAddr == ADDR_FLAG |=> regRdata == $past(flags)) else $error("flag read wrong");
  // Saved word reads back as captured
  a_read_saved: assert property (@(posedge clk) disable iff (!nrst) // [RULE15]
    regRead && regAddr == ADDR_SAVED |=> regRdata == $past(savedFlags))
    else $error("saved read wrong");
  // Unmapped offsets read zero
  a_read_unmapped: assert property (@(posedge clk) disable iff (!nrst) // [RULE14]
    regRead && regAddr > ADDR_IEN |=> regRdata == 16'h0000) else $error("unmapped read not zero");
  // Read data only stands in the cycle after a strobe
  a_read_idle: assert property (@(posedge clk) disable iff (!nrst) // [RULE9]
    !regRead |=> regRdata == 16'h0000) else $error("read data without strobe");
endmodule : cpufr_flag_register

// [hdl/cpufr_pkg.sv]
package cpufr_pkg;
  // Flag register field positions
  localparam int FLG_WIDTH = 16;
  localparam int POS_BANK = 0;
  localparam int POS_OVF = 1;
  localparam int POS_IEN = 2;
  localparam int POS_SSEL = 3;
  localparam int POS_FUF = 4;
  localparam int POS_FOF = 5;
  localparam int POS_RSV = 6;
  localparam int POS_RADIX = 7;
  localparam int POS_RND = 8;
  localparam int POS_PPL = 12;
  localparam logic [15:0] FLG_RESET = 16'h0000;
  localparam logic [15:0] FLG_WMASK = 16'h73bf;
  // Register port offsets
  localparam logic [3:0] ADDR_FLAG = 4'h0;
  localparam logic [3:0] ADDR_SAVED = 4'h1;
  localparam logic [3:0] ADDR_ISTAT = 4'h2;
  localparam logic [3:0] ADDR_ICLR = 4'h3;
  localparam logic [3:0] ADDR_IEN = 4'h4;
  localparam logic [2:0] PPL_BLOCK_ALL = 3'h7;
  localparam logic [7:0] TRAP_MAX_CLEAR = 8'h7f;
  // Event status bits
  localparam int EV_ACCEPT = 0;
  localparam int EV_OVF = 1;
  localparam int EV_FLT = 2;
  localparam int EV_WIDTH = 3;
endpackage : cpufr_pkg

// [testbench/cpufr_flag_register_tb.sv]
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errorCnt++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module cpufr_flag_register_tb;
  import cpufr_pkg::*;
  logic clk, nrst, regWrite, regRead, arithDone, arithOverflow, floatDone, trapExec;
  logic floatUnderflow, floatOverflow, floatSubnormal, irqRequest, irqMaskable, irqOut;
  logic irqAccept, registerBank, userStackSelect, radixPointSelect;
  logic [3:0] regAddr;
  logic [15:0] regWdata, regRdata, flagWord, flg, saved;
  logic [2:0] irqLevel, processorPriorityLevel;
  logic [1:0] roundingModeField;
  logic [7:0] trapNumber;
  logic [31:0] seed = 32'h3d2d, r;
  int errorCnt, comparisons;
  cpufr_flag_register i_dut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .arithDone(arithDone),
    .arithOverflow(arithOverflow), .floatDone(floatDone), .floatUnderflow(floatUnderflow),
    .floatOverflow(floatOverflow), .floatSubnormal(floatSubnormal), .irqRequest(irqRequest),
    .irqLevel(irqLevel), .irqMaskable(irqMaskable), .trapExec(trapExec),
    .trapNumber(trapNumber), .irqAccept(irqAccept), .registerBank(registerBank),
    .userStackSelect(userStackSelect), .radixPointSelect(radixPointSelect),
    .roundingModeField(roundingModeField), .processorPriorityLevel(processorPriorityLevel),
    .flagWord(flagWord), .irqOut(irqOut));
  // Xorshift keeps the random stream repeatable across runs
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk); regWrite <= 1'b1; regAddr <= a; regWdata <= d;
    @(posedge clk); regWrite <= 1'b0;
  endtask : wr
  // Read data is only valid in the cycle after the strobe, so look just after that edge
  task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk); regRead <= 1'b1; regAddr <= a;
    @(posedge clk); regRead <= 1'b0;
    #1 `CHK(regRdata, e)
  endtask : rdchk
  task automatic wflag(input logic [15:0] d);
    wr(ADDR_FLAG, d);
    flg = d & FLG_WMASK;
    #1 `CHK(flagWord, flg)
    `CHK({processorPriorityLevel, roundingModeField, radixPointSelect, userStackSelect, registerBank}, {flg[14:12], flg[9:8], flg[7], flg[3], flg[0]})
  endtask : wflag
  task automatic irq(input logic [2:0] lv, input logic m);
    logic acc;
    acc = lv > flg[14:12] && flg[14:12] != PPL_BLOCK_ALL && (!m || flg[POS_IEN]);
    @(posedge clk); irqRequest <= 1'b1; irqLevel <= lv; irqMaskable <= m;
    #1 `CHK(irqAccept, acc)
    if (acc) begin
      saved = flg;
      flg[POS_IEN] = 1'b0;
      flg[POS_SSEL] = 1'b0;
    end
    @(posedge clk); irqRequest <= 1'b0;
    #1 `CHK(flagWord, flg)
  endtask : irq
  // One event pulse, then the flag word must show the modelled outcome
  task automatic ev(input logic [2:0] k, input logic [3:0] v);
    @(posedge clk); arithDone <= k[0]; floatDone <= k[1]; trapExec <= k[2];
    {arithOverflow, floatUnderflow, floatOverflow, floatSubnormal} <= v;
    trapNumber <= {v, 4'h0};
    @(posedge clk); {arithDone, floatDone, trapExec} <= 3'h0;
    if (k[0]) flg[POS_OVF] = v[3];
    if (k[1]) {flg[POS_FUF], flg[POS_FOF]} = {v[2] | v[0], v[1] | v[0]};
    if (k[2] && {v, 4'h0} <= TRAP_MAX_CLEAR) flg[POS_SSEL] = 1'b0;
    #1 `CHK(flagWord, flg)
  endtask : ev
  // Free-running core clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Watchdog so a hang still reaches the verdict
  initial begin
    #300000 errorCnt++;
    test_done();
  end
  // Main sequence
  initial begin
    {nrst, regWrite, regRead, arithDone, arithOverflow, floatDone, trapExec} = 7'h0;
    {floatUnderflow, floatOverflow, floatSubnormal, irqRequest, irqMaskable} = 5'h0;
    {regAddr, regWdata, irqLevel, trapNumber} = 31'h0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    flg = FLG_RESET;
    rdchk(ADDR_FLAG, FLG_RESET);
    wflag(16'hffbf);
    irq(3'h7, 1'b0);
    wflag(16'h200c);
    irq(3'h2, 1'b1);
    irq(3'h3, 1'b1);
    rdchk(ADDR_SAVED, saved);
    irq(3'h5, 1'b1);
    irq(3'h5, 1'b0);
    $display("interrupt test finished");
    wr(ADDR_IEN, 16'h0007);
    #1 `CHK(irqOut, 1'b1)
    wr(ADDR_IEN, 16'h0000);
    #1 `CHK(irqOut, 1'b0)
    wr(ADDR_ICLR, 16'h0007);
    rdchk(ADDR_ISTAT, 16'h0000);
    rdchk(4'hf, 16'h0000);
    for (int i = 0; i < 16; i++) ev(3'h1 << (i % 3), 4'(i));
    wflag(16'h0008);
    ev(3'h4, 4'h7);
    wflag(16'h0008);
    ev(3'h4, 4'h8);
    rdchk(ADDR_ISTAT, 16'h0006);
    $display("event test finished");
    for (int i = 0; i < 60; i++) begin
      r = rnd();
      wflag(r[15:0] & 16'hffbf);
      irq(r[18:16], r[19]);
    end
    $display("random test finished");
    test_done();
  end
endmodule : cpufr_flag_register_tb
